// ==== serial_adc_pkg.sv ====
package serial_adc_pkg;

   // system clock and documented times
   localparam int CLK_PERIOD_NS    = 20;
   localparam int CONV_TIME_NS     = 21000;
   localparam int CYCLE_TIME_NS    = 31000;
   // longest times round down to whole cycles
   localparam int CONV_MAX_CYCLES  = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CYCLE_MAX_CYCLES = CYCLE_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_SYS_CYCLES  = 44;

   // serial framing
   localparam int RESULT_BITS      = 10;
   localparam int ADDR_BITS        = 4;
   localparam int CNT_BITS         = 4;
   localparam int CONV_CNT_BITS    = 6;
   localparam int ADDR_CLOCKS      = 4;
   localparam int FRAME_CLOCKS     = 10;
   localparam int CS_RISE_EDGES    = 2;
   localparam int FIFO_DEPTH       = 16;

   // channel codes and result values
   localparam logic [ADDR_BITS-1:0]   TEST_CHANNEL = 4'hb;
   localparam logic [RESULT_BITS-1:0] TEST_CODE    = 10'h200;
   localparam logic [RESULT_BITS-1:0] RESET_RESULT = 10'h000;

   typedef enum logic [1:0] {PH_IDLE, PH_SHIFT, PH_CONVERT} phase_t;

   // whole state of the sequencer
   typedef struct packed {
      logic [1:0]               cs_sync;
      logic [1:0]               io_sync;
      logic [1:0]               addr_sync;
      logic                     io_prev;
      logic                     cs_low;
      logic [1:0]               cs_stage;
      phase_t                   phase;
      logic [CNT_BITS-1:0]      bit_cnt;
      logic [ADDR_BITS-1:0]     addr_sr;
      logic [ADDR_BITS-1:0]     channel;
      logic [RESULT_BITS-1:0]   out_sr;
      logic [RESULT_BITS-1:0]   last_result;
      logic [RESULT_BITS-1:0]   held_code;
      logic                     data_bit;
      logic                     sampling;
      logic                     hold;
      logic [CONV_CNT_BITS-1:0] conv_cnt;
   } seq_state_t;

endpackage

// ==== serial_adc_control_sequencer.sv ====
`timescale 1ns/100ps
// Functional notes
// - chip select high: output floats, inputs ignored
// - low select recognised after two rises, one fall
// - recognised low presents previous result msb
// - four-bit address captured msb first on rises
// - first four falls shift out bits two-five
// - sampling starts after fourth falling edge
// - five more falls shift out bits six-ten
// - tenth fall holds, converts in 44 cycles
// - recognised select fall resets, aborts conversion
// - new full sequence aborts, shifts older result
// - shared clock: shift clock low, conversion high
// - shared clock: first two cycles shift nothing
// - conversion starts at tenth fall exactly
// - conversion within 21 us, cycle 31 us
// - system and shift clocks fully independent; code samples the shift clock with the system clock through a synchroniser
// - address 1011 selects internal test channel

// result buffer between converter and output shifter
module result_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0]   count;
   } fifo_state_t;

   fifo_state_t      state_reg;
   fifo_state_t      state_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             do_push;
   logic             do_pop;

   initial
   begin
      if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
         $error("result_fifo: depth must be a power of two");
   end

   // honest full and empty flags
   assign in_ready_out  = (state_reg.count != (PW+1)'(DEPTH));
   assign out_valid_out = (state_reg.count != '0);
   assign out_data_out  = mem[state_reg.rd_ptr];
   assign do_push       = in_valid_in & in_ready_out;
   assign do_pop        = out_ready_in & out_valid_out;

   // pointer and count update
   always_comb
   begin
      state_next = state_reg;
      if (do_push)
         state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
      if (do_pop)
         state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
      if (do_push && !do_pop)
         state_next.count = state_reg.count + 1'b1;
      else if (do_pop && !do_push)
         state_next.count = state_reg.count - 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   // storage array, written on push only
   always_ff @(posedge clk_in)
   begin
      if (do_push)
         mem[state_reg.wr_ptr] <= in_data_in;
   end
endmodule

module serial_adc_control_sequencer #(
   parameter int CONV_CYCLES = serial_adc_pkg::CONV_SYS_CYCLES,
   parameter int BUF_DEPTH   = serial_adc_pkg::FIFO_DEPTH
) (
   input  wire logic                                  clk_in,
   input  wire logic                                  nrst_in,
   input  wire logic                                  cs_n_in,
   input  wire logic                                  addr_in,
   input  wire logic                                  io_clk_in,
   input  wire logic                                  shared_clk_mode_in,
   input  wire logic [serial_adc_pkg::RESULT_BITS-1:0] adc_code_in,
   output logic                                       data_out,
   output logic                                       data_oe_out,
   output logic [serial_adc_pkg::ADDR_BITS-1:0]        channel_out,
   output logic                                       sampling_out,
   output logic                                       hold_out,
   output logic                                       converting_out
);
   serial_adc_pkg::seq_state_t                   state_reg;
   serial_adc_pkg::seq_state_t                   state_next;
   logic                                         io_rise;
   logic                                         io_fall;
   logic                                         conv_tick;
   logic                                         push_valid;
   logic                                         push_ready;
   logic                                         pop_ready;
   logic                                         pop_valid;
   logic [serial_adc_pkg::RESULT_BITS-1:0]       pop_data;
   logic [serial_adc_pkg::RESULT_BITS-1:0]       word;
   logic                                         arm;

   // conversion must fit the longest conversion time
   initial
   begin
      if (CONV_CYCLES < 1 || CONV_CYCLES > serial_adc_pkg::CONV_MAX_CYCLES)
         $error("conversion count outside the conversion time");
      if (CONV_CYCLES > (1 << serial_adc_pkg::CONV_CNT_BITS))
         $error("conversion count too wide for its counter");
   end

   result_fifo #(
      .WIDTH (serial_adc_pkg::RESULT_BITS),
      .DEPTH (BUF_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .nrst_in       (nrst_in),
      .in_valid_in   (push_valid),
      .in_ready_out  (push_ready),
      .in_data_in    (state_reg.held_code),
      .out_valid_out (pop_valid),
      .out_ready_in  (pop_ready),
      .out_data_out  (pop_data)
   );

   // shift clock edges from the synchronised pin
   assign io_rise   = state_reg.io_sync[1] & ~state_reg.io_prev;
   assign io_fall   = ~state_reg.io_sync[1] & state_reg.io_prev;
   // shared mode: common clock runs conversion only while select high
   assign conv_tick = shared_clk_mode_in ? (io_rise & ~state_reg.cs_low) : 1'b1;

   // sequencer next state
   always_comb
   begin
      state_next = state_reg;
      push_valid = 1'b0;
      pop_ready  = 1'b0;
      arm        = 1'b0;
      word       = state_reg.last_result;
      // two-flop synchronisers on select, clock and address pins
      state_next.cs_sync   = {state_reg.cs_sync[0], cs_n_in};
      state_next.io_sync   = {state_reg.io_sync[0], io_clk_in};
      state_next.addr_sync = {state_reg.addr_sync[0], addr_in};
      state_next.io_prev   = state_reg.io_sync[1];

      // conversion counter, waits for buffer room at the end
      if (state_reg.phase == serial_adc_pkg::PH_CONVERT && conv_tick)
      begin
         if (state_reg.conv_cnt == serial_adc_pkg::CONV_CNT_BITS'(CONV_CYCLES - 1))
         begin
            push_valid = 1'b1;
            if (push_ready)
            begin
               state_next.phase = serial_adc_pkg::PH_IDLE;
               state_next.hold  = 1'b0;
            end
         end
         else
            state_next.conv_cnt = state_reg.conv_cnt + 1'b1;
      end

      if (state_reg.cs_sync[1] && !(shared_clk_mode_in && state_reg.cs_low))
      begin
         // select high: shifter idle, pins ignored
         state_next.cs_low   = 1'b0;
         state_next.cs_stage = '0;
      end
      else if (!state_reg.cs_low)
      begin
         // filter: two rising edges then a falling edge
         if (state_reg.cs_stage != 2'(serial_adc_pkg::CS_RISE_EDGES))
         begin
            if (!shared_clk_mode_in || io_rise)
               state_next.cs_stage = state_reg.cs_stage + 1'b1;
         end
         else if (!shared_clk_mode_in || io_fall)
         begin
            state_next.cs_low   = 1'b1;
            state_next.cs_stage = '0;
            state_next.phase    = serial_adc_pkg::PH_IDLE;
            state_next.sampling = 1'b0;
            state_next.hold     = 1'b0;
            state_next.conv_cnt = '0;
            arm                 = 1'b1;
         end
      end
      else
      begin
         unique case (state_reg.phase)
            serial_adc_pkg::PH_IDLE,
            serial_adc_pkg::PH_SHIFT:
            begin
               if (io_rise)
               begin
                  state_next.phase = serial_adc_pkg::PH_SHIFT;
                  if (state_reg.bit_cnt < serial_adc_pkg::CNT_BITS'(serial_adc_pkg::ADDR_CLOCKS))
                     state_next.addr_sr = {state_reg.addr_sr[serial_adc_pkg::ADDR_BITS-2:0],
                                           state_reg.addr_sync[1]};
               end
               else if (io_fall && state_reg.phase == serial_adc_pkg::PH_SHIFT)
               begin
                  // next result bit, msb side first
                  state_next.bit_cnt  = state_reg.bit_cnt + 1'b1;
                  state_next.out_sr   = {state_reg.out_sr[serial_adc_pkg::RESULT_BITS-2:0], 1'b0};
                  state_next.data_bit = state_reg.out_sr[serial_adc_pkg::RESULT_BITS-2];
                  if (state_reg.bit_cnt == serial_adc_pkg::CNT_BITS'(serial_adc_pkg::ADDR_CLOCKS - 1))
                  begin
                     state_next.channel  = state_reg.addr_sr;
                     state_next.sampling = 1'b1;
                  end
                  if (state_reg.bit_cnt == serial_adc_pkg::CNT_BITS'(serial_adc_pkg::FRAME_CLOCKS - 1))
                  begin
                     // hold at the tenth fall, convert at once
                     state_next.sampling  = 1'b0;
                     state_next.hold      = 1'b1;
                     state_next.phase     = serial_adc_pkg::PH_CONVERT;
                     state_next.conv_cnt  = '0;
                     state_next.held_code = (state_reg.channel == serial_adc_pkg::TEST_CHANNEL)
                                            ? serial_adc_pkg::TEST_CODE : adc_code_in;
                     arm                  = 1'b1;
                  end
               end
               else if (state_reg.phase == serial_adc_pkg::PH_IDLE && state_reg.bit_cnt == '0 && pop_valid)
                  arm = 1'b1; // fresh result while idle with select low
            end
            serial_adc_pkg::PH_CONVERT:
            begin
               // outside shared mode, a new sequence abandons the running conversion
               if (io_rise && !shared_clk_mode_in)
               begin
                  state_next.phase    = serial_adc_pkg::PH_SHIFT;
                  state_next.hold     = 1'b0;
                  state_next.conv_cnt = '0;
                  state_next.addr_sr  = {state_reg.addr_sr[serial_adc_pkg::ADDR_BITS-2:0],
                                         state_reg.addr_sync[1]};
               end
            end
            default:
               state_next.phase = serial_adc_pkg::PH_IDLE;
         endcase
         // shared mode: a high select also needs two rises then a fall
         if (state_reg.cs_sync[1])
         begin
            if (state_reg.cs_stage != 2'(serial_adc_pkg::CS_RISE_EDGES))
            begin
               if (io_rise)
                  state_next.cs_stage = state_reg.cs_stage + 1'b1;
            end
            else if (io_fall)
            begin
               // tenth fall handled above, common clock now converts
               state_next.cs_low   = 1'b0;
               state_next.cs_stage = '0;
            end
         end
         else
            state_next.cs_stage = '0;
      end

      // load the output shifter from buffer or last result
      if (arm)
      begin
         pop_ready              = pop_valid;
         word                   = pop_valid ? pop_data : state_reg.last_result;
         state_next.last_result = word;
         state_next.out_sr      = word;
         state_next.data_bit    = word[serial_adc_pkg::RESULT_BITS-1];
         state_next.bit_cnt     = '0;
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         state_reg             <= '0;
         state_reg.cs_sync     <= 2'h3;
         state_reg.phase       <= serial_adc_pkg::PH_IDLE;
         state_reg.last_result <= serial_adc_pkg::RESET_RESULT;
      end
      else
         state_reg <= state_next;
   end

   // pin and status outputs
   assign data_out       = state_reg.data_bit;
   assign data_oe_out    = state_reg.cs_low & ~state_reg.cs_sync[1];
   assign channel_out    = state_reg.channel;
   assign sampling_out   = state_reg.sampling;
   assign hold_out       = state_reg.hold;
   assign converting_out = (state_reg.phase == serial_adc_pkg::PH_CONVERT);
endmodule

// ==== serial_adc_sva.sv ====
`timescale 1ns/100ps
// port-level checks of the sequencer
module serial_adc_checker #(
   parameter int CONV_CYCLES = 44,
   parameter int BUF_DEPTH   = 16
) (
   input wire logic       clk_in,
   input wire logic       nrst_in,
   input wire logic       cs_n_in,
   input wire logic       addr_in,
   input wire logic       io_clk_in,
   input wire logic       shared_clk_mode_in,
   input wire logic [9:0] adc_code_in,
   input wire logic       data_out,
   input wire logic       data_oe_out,
   input wire logic [3:0] channel_out,
   input wire logic       sampling_out,
   input wire logic       hold_out,
   input wire logic       converting_out
);
   logic [7:0] cs_hi_cnt, cs_lo_cnt, io_hi_cnt, conv_len;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // run lengths of select levels, shift clock high and conversion
   always_ff @(posedge clk_in)
   begin
      cs_hi_cnt <= (!nrst_in || !cs_n_in) ? 8'h00 : cs_hi_cnt + {7'h00, cs_hi_cnt != 8'hff};
      cs_lo_cnt <= (!nrst_in || cs_n_in) ? 8'h00 : cs_lo_cnt + {7'h00, cs_lo_cnt != 8'hff};
      io_hi_cnt <= (!nrst_in || !io_clk_in) ? 8'h00 : io_hi_cnt + {7'h00, io_hi_cnt != 8'hff};
      conv_len  <= (!nrst_in || !converting_out) ? 8'h00 : conv_len + {7'h00, conv_len != 8'hff};
   end

   a_oe_idle_off: assert property (cs_hi_cnt >= 8 |-> !data_oe_out)
      else $error("data driven while select high");
   a_shift_ignored: assert property (cs_hi_cnt >= 8 |-> $stable(channel_out))
      else $error("channel moved while select high");
   a_oe_filter_wait: assert property ((!cs_n_in && cs_hi_cnt >= 8) |-> !data_oe_out [*3])
      else $error("select low taken too early");
   a_oe_recognised: assert property ((!shared_clk_mode_in && cs_lo_cnt >= 10) |-> data_oe_out)
      else $error("select low never recognised");
   a_chan_on_sample: assert property (!$stable(channel_out) |-> $rose(sampling_out))
      else $error("channel changed outside fourth fall");
   a_sample_hold_excl: assert property (sampling_out |-> !hold_out)
      else $error("sampling and hold together");
   a_hold_starts_conv: assert property ($rose(hold_out) |-> ##[0:1] (converting_out && !sampling_out))
      else $error("hold without conversion");
   a_hold_after_sample: assert property (($fell(sampling_out) && data_oe_out && !shared_clk_mode_in)
      |-> ##[0:1] hold_out)
      else $error("sampling ended without hold");
   a_conv_bounded: assert property ((converting_out && !shared_clk_mode_in) |-> conv_len < CONV_CYCLES + 2)
      else $error("conversion runs too long");
   a_data_steady: assert property ((io_hi_cnt >= 6 && !shared_clk_mode_in) |-> $stable(data_out))
      else $error("data changed without shift clock fall");
   a_shared_oe_wait: assert property ((shared_clk_mode_in && !cs_n_in && cs_hi_cnt >= 8) |-> !data_oe_out [*8])
      else $error("shared select taken before its clocks");
endmodule

bind serial_adc_control_sequencer serial_adc_checker #(.CONV_CYCLES(CONV_CYCLES), .BUF_DEPTH(BUF_DEPTH)) u_chk (
   .clk_in, .nrst_in, .cs_n_in, .addr_in, .io_clk_in, .shared_clk_mode_in, .adc_code_in,
   .data_out, .data_oe_out, .channel_out, .sampling_out, .hold_out, .converting_out);

// ==== host_model.sv ====
`timescale 1ns/100ps
// host side of the serial link, 160 ns shift clock
module host_model (
   output logic      cs_n_out,
   output logic      addr_out,
   output logic      io_clk_out,
   input  wire logic data_in
);
   // idle: deselected, clock parked low
   initial
   begin
      cs_n_out   = 1'b1;
      addr_out   = 1'b0;
      io_clk_out = 1'b0;
   end

   // select or deselect, then give recognition time
   task automatic select(input logic lo);
      cs_n_out = !lo;
      addr_out = !addr_out;
      #400;
   endtask

   // ten clocks: address msb first, result read at end of each high phase
   task automatic frame(input logic [3:0] a, input int stretch, output logic [9:0] rd);
      for (int i = 0; i < 10; i++)
      begin
         addr_out = (i < 4) ? a[3-i] : !addr_out;
         #40;
         io_clk_out = 1'b1;
         #75;
         if (i == 9)
            #(stretch);
         rd[9-i] = data_in;
         #5;
         io_clk_out = 1'b0;
         #40;
      end
      addr_out = !addr_out; // clock left low afterwards
   endtask

   // shared clock: two recognition clocks, ten frame clocks, conversion clocks
   task automatic shared_frame(input logic [3:0] a, output logic [9:0] rd);
      cs_n_out = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         addr_out = (i >= 2 && i < 6) ? a[5-i] : !addr_out;
         #40;
         io_clk_out = 1'b1;
         #75;
         if (i >= 2)
            rd[11-i] = data_in;
         #5;
         io_clk_out = 1'b0;
         #40;
         if (i == 9)
            cs_n_out = 1'b1; // raised after the eighth recognised clock
      end
      repeat (50)
      begin
         #80;
         io_clk_out = 1'b1;
         #80;
         io_clk_out = 1'b0; // common clock drives the conversion
      end
   endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
   logic       clk_in   = 1'b0;
   logic       nrst_in  = 1'b0;
   logic [9:0] adc_code = 10'h000;
   logic [9:0] prev_res, rd;
   logic [3:0] a;
   logic       shared_mode = 1'b0;
   wire logic  cs_n_in, addr_in, io_clk_in, data_out, data_oe_out, sampling_out, hold_out, converting_out;
   wire logic [3:0] channel_out;
   int         n_errors  = 0;
   int         cmp_count = 0;
   int         seed      = 22;

   always #10 clk_in = !clk_in;

   serial_adc_control_sequencer u_serial_adc_control_sequencer (.clk_in, .nrst_in, .cs_n_in, .addr_in,
      .io_clk_in, .shared_clk_mode_in(shared_mode), .adc_code_in(adc_code), .data_out, .data_oe_out,
      .channel_out, .sampling_out, .hold_out, .converting_out);
   host_model u_host_model (.cs_n_out(cs_n_in), .addr_out(addr_in), .io_clk_out(io_clk_in), .data_in(data_out));

   // code the front end should deliver for a channel
   function automatic logic [9:0] exp_code(input logic [3:0] ch, input logic [9:0] code);
      return (ch == serial_adc_pkg::TEST_CHANNEL) ? serial_adc_pkg::TEST_CODE : code;
   endfunction

   // verdict and end of run
   task automatic summarize();
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one frame with a fresh random code, readout checked
   task automatic one_frame(input logic [3:0] ad, input int stretch);
      repeat (4) @(negedge clk_in);
      adc_code = 10'($random(seed));
      a = ad;
      u_host_model.frame(ad, stretch, rd);
      `CHK("result", prev_res, rd)
      `CHK("channel", ad, channel_out)
   endtask

   // conversion runs its full length, then result becomes current
   task automatic wait_conv();
      repeat (10) @(negedge clk_in);
      `CHK("hold", 1'b1, hold_out)
      `CHK("sampling", 1'b0, sampling_out)
      repeat (30) @(negedge clk_in);
      `CHK("conv_busy", 1'b1, converting_out)
      for (int k = 0; k < 20 && converting_out !== 1'b0; k++)
         @(negedge clk_in);
      `CHK("conv_done", 1'b0, converting_out)
      prev_res = exp_code(a, adc_code);
   endtask

   // hang guard
   initial
   begin
      #200000;
      n_errors++;
      summarize();
   end

   initial
   begin
      repeat (12) @(negedge clk_in);
      nrst_in = 1'b1;
      prev_res = serial_adc_pkg::RESET_RESULT;
      `CHK("oe_reset", 1'b0, data_oe_out)
      u_host_model.select(1'b1);
      `CHK("oe_sel", 1'b1, data_oe_out)
      // test channel, zero, stretched tenth cycle, then random channels
      for (int i = 0; i < 8; i++)
      begin
         one_frame((i == 0) ? 4'hb : (i == 1) ? 4'h0 : 4'($random(seed)), (i == 2) ? 300 : 0);
         wait_conv();
      end
      // new frame during conversion aborts it
      one_frame(4'h3, 0);
      one_frame(4'h5, 0);
      wait_conv();
      // select pulse during conversion aborts it
      one_frame(4'h9, 0);
      u_host_model.select(1'b0);
      `CHK("oe_desel", 1'b0, data_oe_out)
      u_host_model.select(1'b1);
      `CHK("aborted", 1'b0, converting_out)
      one_frame(4'ha, 0);
      wait_conv();
      // shift clock while deselected is ignored
      u_host_model.select(1'b0);
      u_host_model.frame(4'h7, 0, rd);
      `CHK("chan_desel", a, channel_out)
      `CHK("samp_desel", 1'b0, sampling_out)
      u_host_model.select(1'b1);
      one_frame(4'hb, 0);
      wait_conv();
      // shared clock mode: common clock shifts, then converts with select high
      u_host_model.select(1'b0);
      shared_mode = 1'b1;
      for (int j = 0; j < 2; j++)
      begin
         adc_code = 10'($random(seed));
         a = (j == 0) ? 4'h6 : 4'($random(seed));
         u_host_model.shared_frame(a, rd);
         `CHK("sh_result", prev_res, rd)
         `CHK("sh_channel", a, channel_out)
         `CHK("sh_conv_done", 1'b0, converting_out)
         prev_res = exp_code(a, adc_code);
      end
      summarize();
   end
endmodule
